// file: common/rsl_pkg.sv
// Shared constants and types of the reset source logic
package rsl_pkg;

    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned CLOCK_LOSS_TIME_US = 100;
    // Least time: round up to whole cycles
    localparam int unsigned CLOCK_LOSS_CYCLES = (CLOCK_LOSS_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CLOCK_LOSS_CNT_W = 12;
    localparam int unsigned WDT_CLK_DIV = 12;
    localparam int unsigned WDT_DIV_W = 4;
    localparam int unsigned WDT_CNT_W = 16;
    localparam int unsigned WDT_LIMIT_DEF = 256;
    localparam int unsigned RESET_HOLD_DEF = 16;
    localparam int unsigned HOLD_CNT_W = 8;

    // Register offsets
    localparam logic [7:0] ADDR_RESET_SOURCE = 8'h00;
    localparam logic [7:0] ADDR_WDT_CTRL = 8'h04;
    localparam logic [7:0] ADDR_WDT_COUNT = 8'h08;

    // Reset source register fields
    localparam int unsigned BIT_PIN = 0;
    localparam int unsigned BIT_CLOCK_LOSS = 2;
    localparam int unsigned BIT_WATCHDOG = 3;
    localparam int unsigned BIT_SOFTWARE = 4;
    localparam int unsigned BIT_COMPARATOR = 5;
    localparam int unsigned BIT_FLASH_ERROR = 6;
    localparam logic [7:0] RESET_SOURCE_RST = 8'h00;

    // Watchdog control fields
    localparam int unsigned WDT_BIT_ENABLE = 0;
    localparam int unsigned WDT_BIT_KICK = 1;
    localparam logic WDT_ENABLE_RST = 1'b1;

    typedef enum logic [1:0] {
        RSL_FLASH_WRITE_ERASE,
        RSL_FLASH_DATA_READ,
        RSL_FLASH_FETCH
    } rsl_flash_kind_t;

    typedef struct packed {
        logic valid;
        rsl_flash_kind_t kind;
        logic [15:0] addr;
        logic security_block;
    } rsl_flash_req_t;

    typedef struct packed {
        logic flash_write_enable;
        logic supply_monitor_on;
        logic supply_monitor_high;
        logic [15:0] lock_byte_addr;
    } rsl_flash_cfg_t;

    typedef enum logic [1:0] {
        RSL_RUN,
        RSL_PIN,
        RSL_HOLD
    } rsl_state_t;

endpackage

// file: core/rsl_core.sv
// Reset source logic: reset causes, system reset output and cause flags
`timescale 1ns/100ps

module rsl_core #(
    parameter int unsigned WDT_LIMIT = rsl_pkg::WDT_LIMIT_DEF,
    parameter int unsigned RESET_HOLD = rsl_pkg::RESET_HOLD_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic system_clock,
    input wire logic comparator_out,
    input wire logic ext_rst_n,
    input wire rsl_pkg::rsl_flash_req_t flash_req,
    input wire rsl_pkg::rsl_flash_cfg_t flash_cfg,
    output logic sys_rst_n,
    output logic rst_pin_out,
    output logic rst_pin_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // Derived constants

    localparam logic [rsl_pkg::CLOCK_LOSS_CNT_W-1:0] LOSS_LAST =
        rsl_pkg::CLOCK_LOSS_CNT_W'(rsl_pkg::CLOCK_LOSS_CYCLES - 1);
    localparam logic [rsl_pkg::WDT_DIV_W-1:0] DIV_LAST = rsl_pkg::WDT_DIV_W'(rsl_pkg::WDT_CLK_DIV - 1);
    localparam logic [rsl_pkg::WDT_CNT_W-1:0] WDT_LAST = rsl_pkg::WDT_CNT_W'(WDT_LIMIT - 1);
    localparam logic [rsl_pkg::HOLD_CNT_W-1:0] HOLD_LAST = rsl_pkg::HOLD_CNT_W'(RESET_HOLD - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    rsl_pkg::rsl_state_t state_q;
    logic [rsl_pkg::HOLD_CNT_W-1:0] hold_cnt_q;
    logic [7:0] flags_q;
    logic [7:0] cause;
    logic run;
    logic clock_loss_en_q;
    logic comp_en_q;
    logic system_clock_prev_q;
    logic [rsl_pkg::CLOCK_LOSS_CNT_W-1:0] loss_cnt_q;
    logic clock_loss_trip;
    logic [rsl_pkg::WDT_DIV_W-1:0] div_q;
    logic wdt_tick;
    logic wdt_en_q;
    logic [rsl_pkg::WDT_CNT_W-1:0] wdt_cnt_q;
    logic wdt_expire;
    logic comp_trip;
    logic flash_write_try;
    logic flash_above_lock;
    logic flash_err;
    logic sw_trip;
    logic apb_write;
    logic hit_src;
    logic hit_ctrl;
    logic hit_count;
    logic [31:0] prdata_q;

    assign run = (state_q == rsl_pkg::RSL_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states

    assign pready = 1'b1;
    assign apb_write = psel && penable && pwrite;

    always_comb begin
        hit_src = 1'b0;
        hit_ctrl = 1'b0;
        hit_count = 1'b0;
        if (paddr == rsl_pkg::ADDR_RESET_SOURCE) begin
            hit_src = 1'b1;
        end else if (paddr == rsl_pkg::ADDR_WDT_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (paddr == rsl_pkg::ADDR_WDT_COUNT) begin
            hit_count = 1'b1;
        end
    end

    assign pslverr = psel && penable && !(hit_src || hit_ctrl || hit_count);

    // Read data captured in the setup cycle so it leaves a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable) begin
            if (hit_src) begin
                prdata_q <= {24'h00_0000, flags_q};
            end else if (hit_ctrl) begin
                prdata_q <= {31'h0000_0000, wdt_en_q};
            end else if (hit_count) begin
                prdata_q <= {16'h0000, wdt_cnt_q};
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    assign prdata = prdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Source enables

    // Enables reflect the written value, never the read-back flags
    // clock-loss enable write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_loss_en_q <= 1'b0;
        end else if (!run) begin
            clock_loss_en_q <= 1'b0;
        end else if (apb_write && hit_src) begin
            clock_loss_en_q <= pwdata[rsl_pkg::BIT_CLOCK_LOSS];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_en_q <= 1'b0;
        end else if (!run) begin
            comp_en_q <= 1'b0;
        end else if (apb_write && hit_src) begin
            comp_en_q <= pwdata[rsl_pkg::BIT_COMPARATOR];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock-loss detector

    // The monitored clock is sampled, so only stalls far above a pclk period count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_clock_prev_q <= 1'b0;
        end else begin
            system_clock_prev_q <= system_clock;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loss_cnt_q <= '0;
        end else if (!run || !clock_loss_en_q || (system_clock != system_clock_prev_q)) begin
            loss_cnt_q <= '0;
        end else if (loss_cnt_q != LOSS_LAST) begin
            loss_cnt_q <= loss_cnt_q + 1'b1;
        end
    end

    assign clock_loss_trip = clock_loss_en_q && (loss_cnt_q == LOSS_LAST) && (system_clock == system_clock_prev_q);

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
        end else if (!run || wdt_tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    assign wdt_tick = run && (div_q == DIV_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_en_q <= rsl_pkg::WDT_ENABLE_RST;
        end else if (!run) begin
            wdt_en_q <= rsl_pkg::WDT_ENABLE_RST;
        end else if (apb_write && hit_ctrl) begin
            wdt_en_q <= pwdata[rsl_pkg::WDT_BIT_ENABLE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_cnt_q <= '0;
        end else if (!run || !wdt_en_q || (apb_write && hit_ctrl && pwdata[rsl_pkg::WDT_BIT_KICK])) begin
            wdt_cnt_q <= '0;
        end else if (wdt_tick) begin
            wdt_cnt_q <= wdt_cnt_q + 1'b1;
        end
    end

    assign wdt_expire = wdt_en_q && wdt_tick && (wdt_cnt_q == WDT_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // Comparator, flash and software sources

    assign comp_trip = comp_en_q && !comparator_out;

    assign flash_write_try = flash_req.valid && (flash_req.kind == rsl_pkg::RSL_FLASH_WRITE_ERASE) &&
        flash_cfg.flash_write_enable;
    assign flash_above_lock = flash_req.addr > flash_cfg.lock_byte_addr;

    assign flash_err = (flash_write_try && flash_above_lock) ||
        (flash_req.valid && (flash_req.kind == rsl_pkg::RSL_FLASH_DATA_READ) && flash_above_lock) ||
        (flash_req.valid && (flash_req.kind == rsl_pkg::RSL_FLASH_FETCH) && flash_above_lock) ||
        (flash_req.valid && flash_req.security_block) ||
        (flash_write_try && (!flash_cfg.supply_monitor_on || !flash_cfg.supply_monitor_high));

    assign sw_trip = apb_write && hit_src && pwdata[rsl_pkg::BIT_SOFTWARE];

    // one cause, fixed priority when several coincide
    always_comb begin
        cause = 8'h00;
        if (clock_loss_trip) begin
            cause[rsl_pkg::BIT_CLOCK_LOSS] = 1'b1;
        end else if (comp_trip) begin
            cause[rsl_pkg::BIT_COMPARATOR] = 1'b1;
        end else if (wdt_expire) begin
            cause[rsl_pkg::BIT_WATCHDOG] = 1'b1;
        end else if (flash_err) begin
            cause[rsl_pkg::BIT_FLASH_ERROR] = 1'b1;
        end else if (sw_trip) begin
            cause[rsl_pkg::BIT_SOFTWARE] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequencer

    // pin reset holds the sequencer until the pin rises
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= rsl_pkg::RSL_RUN;
        end else if (!ext_rst_n) begin
            state_q <= rsl_pkg::RSL_PIN;
        end else begin
            case (state_q)
                rsl_pkg::RSL_RUN: begin
                    if (cause != 8'h00) begin
                        state_q <= rsl_pkg::RSL_HOLD;
                    end
                end
                rsl_pkg::RSL_PIN: begin
                    state_q <= rsl_pkg::RSL_HOLD;
                end
                rsl_pkg::RSL_HOLD: begin
                    if (hold_cnt_q == HOLD_LAST) begin
                        state_q <= rsl_pkg::RSL_RUN;
                    end
                end
                default: begin
                    state_q <= rsl_pkg::RSL_RUN;
                end
            endcase
        end
    end

    // Every reset except presetn stretched to a fixed minimum low time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt_q <= '0;
        end else if (state_q != rsl_pkg::RSL_HOLD || !ext_rst_n) begin
            hold_cnt_q <= '0;
        end else if (hold_cnt_q != HOLD_LAST) begin
            hold_cnt_q <= hold_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= rsl_pkg::RESET_SOURCE_RST;
        end else if (!ext_rst_n) begin
            flags_q <= 8'h00;
        end else if (state_q == rsl_pkg::RSL_PIN) begin
            flags_q <= 8'h01 << rsl_pkg::BIT_PIN;
        end else if (run && (cause != 8'h00)) begin
            flags_q <= cause;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_rst_n <= 1'b0;
        end else begin
            sys_rst_n <= run && ext_rst_n && (cause == 8'h00);
        end
    end

    // pin never driven by this block
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    AST_LOSS_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
        (run && ext_rst_n && clock_loss_trip) |=> (!sys_rst_n && flags_q[rsl_pkg::BIT_CLOCK_LOSS]))
        else $error("clock loss did not reset");

    AST_LOSS_BOUND: assert property (@(posedge pclk) disable iff (!presetn)
        (loss_cnt_q == LOSS_LAST) |-> (clock_loss_en_q && $stable(system_clock_prev_q)))
        else $error("stall timer full without stall");

    AST_ONE_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == rsl_pkg::RSL_HOLD && $past(state_q) == rsl_pkg::RSL_RUN) |-> $onehot(flags_q))
        else $error("internal reset without single cause");

    AST_LOSS_EN: assert property (@(posedge pclk) disable iff (!presetn)
        (run && apb_write && hit_src && !sw_trip && cause == 8'h00 && ext_rst_n) |=>
        (clock_loss_en_q == $past(pwdata[rsl_pkg::BIT_CLOCK_LOSS])))
        else $error("clock loss enable not written");

    AST_PIN_UNDRIVEN: assert property (@(posedge pclk) disable iff (!presetn)
        !sys_rst_n |-> (!rst_pin_oe && !rst_pin_out))
        else $error("reset pin driven");

    AST_COMP_GATED: assert property (@(posedge pclk) disable iff (!presetn)
        (run && !comp_en_q) |=> !flags_q[rsl_pkg::BIT_COMPARATOR] || $stable(flags_q))
        else $error("comparator reset while disabled");

    AST_COMP_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
        (run && ext_rst_n && comp_en_q && !comparator_out && !clock_loss_trip) |=>
        (!sys_rst_n && flags_q[rsl_pkg::BIT_COMPARATOR]))
        else $error("comparator did not reset");

    AST_WDT_ON: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == rsl_pkg::RSL_HOLD) |=> wdt_en_q)
        else $error("watchdog not enabled after reset");

    AST_WDT_DIV: assert property (@(posedge pclk) disable iff (!presetn)
        wdt_tick |=> !wdt_tick [*8])
        else $error("watchdog tick too frequent");

    AST_WDT_RESET: assert property (@(posedge pclk) disable iff (!presetn)
        (run && ext_rst_n && wdt_expire && !clock_loss_trip && !comp_trip) |=>
        (!sys_rst_n && flags_q == (8'h01 << rsl_pkg::BIT_WATCHDOG)))
        else $error("watchdog expiry did not reset");

    AST_FLASH_RESET: assert property (@(posedge pclk) disable iff (!presetn)
        (run && ext_rst_n && flash_err && !clock_loss_trip && !comp_trip && !wdt_expire) |=>
        (!sys_rst_n && flags_q == (8'h01 << rsl_pkg::BIT_FLASH_ERROR)))
        else $error("flash error did not reset");

    AST_SW_RESET: assert property (@(posedge pclk) disable iff (!presetn)
        (run && ext_rst_n && sw_trip && !clock_loss_trip && !comp_trip && !wdt_expire && !flash_err) |=>
        (!sys_rst_n && flags_q == (8'h01 << rsl_pkg::BIT_SOFTWARE)))
        else $error("software reset not flagged");

    AST_PIN_END: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == rsl_pkg::RSL_PIN && ext_rst_n) |=>
        (!sys_rst_n && flags_q == (8'h01 << rsl_pkg::BIT_PIN)))
        else $error("pin flag not set at pin reset end");

    // First release after presetn has no hold phase, so only held resets count
    AST_HOLD_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(sys_rst_n) && $past(state_q, 2) == rsl_pkg::RSL_HOLD) |-> $past(hold_cnt_q) == HOLD_LAST)
        else $error("reset released early");

endmodule

// file: test/rsl_far_model.sv
// Far-side model: monitored system clock source and comparator output
`timescale 1ns/100ps
module rsl_far_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    input wire logic cmp_below,
    output logic system_clock,
    output logic comparator_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // stalled oscillator
    // A stall keeps the last level, as a dead oscillator would, not a pulled line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_clock <= 1'b0;
        end else if (!stall) begin
            system_clock <= ~system_clock;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // output low while input below reference
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comparator_out <= 1'b1;
        end else begin
            comparator_out <= ~cmp_below;
        end
    end
endmodule

// file: test/reset_source_logic_tb.sv
// Self-checking bench of the reset source logic
`timescale 1ns/100ps
module reset_source_logic_tb;
    localparam int unsigned WDT_LIM = 4;
    localparam int unsigned HOLD = 2;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic system_clock, comparator_out, ext_rst_n, sys_rst_n, rst_pin_out, rst_pin_oe, stall, cmp_below;
    rsl_pkg::rsl_flash_req_t flash_req;
    rsl_pkg::rsl_flash_cfg_t flash_cfg;
    logic [32:0] exp_q[$];
    logic [8:0] fc [8] = '{9'h04F, 9'h0CF, 9'h14F, 9'h09F, 9'h00B, 9'h00D, 9'h0AE, 9'h00E};
    logic [15:0] lock, fa;
    logic [31:0] seed = 32'h00018457;
    int num_errors = 0;
    int cmp_count = 0;

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    rsl_core #(.WDT_LIMIT(WDT_LIM), .RESET_HOLD(HOLD)) i_rsl_core (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .system_clock(system_clock), .comparator_out(comparator_out), .ext_rst_n(ext_rst_n),
        .flash_req(flash_req), .flash_cfg(flash_cfg), .sys_rst_n(sys_rst_n), .rst_pin_out(rst_pin_out),
        .rst_pin_oe(rst_pin_oe));
    rsl_far_model i_rsl_far_model (.pclk(pclk), .presetn(presetn), .stall(stall), .cmp_below(cmp_below),
        .system_clock(system_clock), .comparator_out(comparator_out));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [32:0] fl(int unsigned b);
        return 33'h000000001 << b;
    endfunction

    task automatic tick();
        @(posedge pclk);
    endtask

    task automatic check(logic [32:0] seen, logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic give_up();
        num_errors++;
        $display("MISMATCH t=%0t wait ran out", $time);
        end_of_test();
    endtask

    // Read results are noted here and judged by the monitor below
    task automatic apb(bit wr, logic [7:0] a, logic [31:0] d, logic [32:0] e);
        int n;
        if (!wr) exp_q.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        tick();
        penable <= 1'b1;
        n = 0;
        do begin
            tick();
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) give_up();
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so the next call never reassigns psel in this time step
        tick();
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            check({pslverr, prdata}, exp_q.pop_front());
        end
    end

    task automatic no_rst(int n);
        logic ok;
        ok = 1'b1;
        repeat (n) begin
            tick();
            if (sys_rst_n !== 1'b1) ok = 1'b0;
        end
        check({32'h00000000, ok}, 33'h000000001);
    endtask

    // Watchdog is switched off after each reset, else it would fire mid-scenario
    task automatic wait_rst(int bound, int unsigned b, bit wdt_off);
        int n;
        n = 0;
        while (sys_rst_n !== 1'b0 && n < bound) begin
            tick();
            n++;
        end
        if (sys_rst_n !== 1'b0) give_up();
        check({31'h00000000, rst_pin_out, rst_pin_oe}, 33'h000000000);
        n = 0;
        while (sys_rst_n !== 1'b1 && n < 50) begin
            tick();
            n++;
        end
        if (n >= 50) give_up();
        apb(1'b0, rsl_pkg::ADDR_WDT_CTRL, 32'h00000000, 33'h000000001);
        if (wdt_off) apb(1'b1, rsl_pkg::ADDR_WDT_CTRL, 32'h00000000, 33'h000000000);
        apb(1'b0, rsl_pkg::ADDR_RESET_SOURCE, 32'h00000000, fl(b));
    endtask

    task automatic flash(logic [1:0] k, logic [15:0] a, logic s);
        flash_req <= '{1'b1, rsl_pkg::rsl_flash_kind_t'(k), a, s};
        tick();
        flash_req <= '0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        ext_rst_n = 1'b1;
        stall = 1'b0;
        cmp_below = 1'b0;
        flash_req = '0;
        flash_cfg = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        tick();
        apb(1'b0, rsl_pkg::ADDR_RESET_SOURCE, 32'h00000000, 33'h000000000);
        apb(1'b0, rsl_pkg::ADDR_WDT_CTRL, 32'h00000000, 33'h000000001);
        apb(1'b0, 8'h3C, 32'h00000000, 33'h100000000);
        no_rst(20);
        wait_rst(60, rsl_pkg::BIT_WATCHDOG, 1'b1);
        apb(1'b1, rsl_pkg::ADDR_RESET_SOURCE, 32'h00000010, 33'h000000000);
        wait_rst(20, rsl_pkg::BIT_SOFTWARE, 1'b1);
        cmp_below <= 1'b1;
        no_rst(20);
        apb(1'b1, rsl_pkg::ADDR_RESET_SOURCE, 32'h00000020, 33'h000000000);
        wait_rst(20, rsl_pkg::BIT_COMPARATOR, 1'b1);
        cmp_below <= 1'b0;
        // stall ignored while disabled, then trips near the limit
        stall <= 1'b1;
        no_rst(4100);
        stall <= 1'b0;
        apb(1'b1, rsl_pkg::ADDR_RESET_SOURCE, 32'h00000004, 33'h000000000);
        stall <= 1'b1;
        no_rst(3990);
        wait_rst(30, rsl_pkg::BIT_CLOCK_LOSS, 1'b1);
        stall <= 1'b0;
        lock = 16'h0800 | 16'(rnd() & 32'h00000FFF);
        for (int i = 0; i < 8; i++) begin
            flash_cfg <= '{fc[i][3], fc[i][2], fc[i][1], lock};
            tick();
            if (fc[i][6:5] == 2'h2) fa = lock + 16'h0001 + 16'(rnd() & 32'h000000FF);
            else if (fc[i][6:5] == 2'h1) fa = lock;
            else fa = lock - 16'h0001 - 16'(rnd() & 32'h000000FF);
            flash(fc[i][8:7], fa, fc[i][4]);
            if (fc[i][0]) wait_rst(20, rsl_pkg::BIT_FLASH_ERROR, 1'b1);
            else no_rst(20);
        end
        // regular updates keep the watchdog quiet, then it expires
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, rsl_pkg::ADDR_WDT_CTRL, 32'h00000003, 33'h000000000);
            no_rst(25);
        end
        wait_rst(60, rsl_pkg::BIT_WATCHDOG, 1'b1);
        apb(1'b0, rsl_pkg::ADDR_WDT_COUNT, 32'h00000000, 33'h000000000);
        ext_rst_n <= 1'b0;
        repeat (5) tick();
        check({32'h00000000, sys_rst_n}, 33'h000000000);
        ext_rst_n <= 1'b1;
        wait_rst(20, rsl_pkg::BIT_PIN, 1'b1);
        end_of_test();
    end
endmodule
